// file: common/t1amc_params.svh
`ifndef T1AMC_PARAMS_SVH
`define T1AMC_PARAMS_SVH

// Control port register offsets
`define T1AMC_ADDR_LCV_HIGH 8'h23
`define T1AMC_ADDR_LCV_LOW 8'h24
`define T1AMC_ADDR_PCV_HIGH 8'h25
`define T1AMC_ADDR_PCV_LOW 8'h26
`define T1AMC_ADDR_OOS_LOW 8'h27
`define T1AMC_ADDR_EVENT_MASK 8'h6f
`define T1AMC_ADDR_ALARM_MASK 8'h7f

// Reset values
`define T1AMC_MASK_RESET 8'h00
`define T1AMC_RDATA_IDLE 8'h00

// Counter widths
`define T1AMC_LCV_WIDTH 16
`define T1AMC_PCV_WIDTH 12
`define T1AMC_OOS_WIDTH 12

// Excessive zero run lengths
`define T1AMC_ZERO_RUN_PLAIN 16
`define T1AMC_ZERO_RUN_SUBST 8

// Timing: base tick in ms, clock in MHz, interval lengths in ms
`define T1AMC_TICK_MS 1
`define T1AMC_CLK_MHZ 125
`define T1AMC_TICK_CYCLES (`T1AMC_TICK_MS * `T1AMC_CLK_MHZ * 1000)
`define T1AMC_SEC_SHORT_MS 999
`define T1AMC_SEC_LONG_MS 1002
`define T1AMC_FAST_MS 42

`endif

// file: common/t1amc_pkg.sv
package t1amc_pkg;

  // Alarm sources, bit 7 down to bit 0
  typedef struct packed {
    logic loop_up_detected;
    logic loop_down_detected;
    logic transmit_clock_loss;
    logic elastic_store_slip;
    logic blue_alarm_rx;
    logic yellow_alarm_rx;
    logic carrier_loss;
    logic rx_sync_loss;
  } t1amc_alarm_t;

  // Event sources, bit 7 down to bit 0
  typedef struct packed {
    logic rx_multiframe_tick;
    logic tx_multiframe_tick;
    logic one_second_tick;
    logic rx_facility_link_full;
    logic tx_facility_link_empty;
    logic facility_link_match;
    logic facility_link_abort;
    logic signaling_change;
  } t1amc_event_t;

  // Parallel control port request
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } t1amc_cpu_req_t;

  // One-cycle error strobes from the receive framer
  typedef struct packed {
    logic bit_valid;
    logic bit_zero;
    logic bipolar_violation;
    logic in_subst_codeword;
    logic crc6_error;
    logic ft_error;
    logic fs_error;
    logic fps_error;
    logic multiframe;
  } t1amc_line_evt_t;

  // Framing and counting options
  typedef struct packed {
    logic count_interval_select;
    logic excess_zero_count_enable;
    logic rx_zero_substitution_enable;
    logic framing_mode_select;
    logic fs_error_count_enable;
    logic out_of_sync_count_select;
  } t1amc_cfg_t;

  // Phase of the three-second pattern
  typedef enum logic [1:0] {
    T1AMC_SEC_A,
    T1AMC_SEC_B,
    T1AMC_SEC_C
  } t1amc_sec_phase_t;

endpackage : t1amc_pkg

// file: logic/t1amc_sat_counter.sv
`include "t1amc_params.svh"

module t1amc_sat_counter #(
  parameter int WIDTH = 16
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // Control
  input wire logic inc,
  input wire logic boundary,
  // Value from the previous interval
  output logic [WIDTH-1:0] shown_q
);

  logic [WIDTH-1:0] acc_q;
  logic [WIDTH-1:0] acc_d;
  logic [WIDTH-1:0] shown_d;
  logic [WIDTH-1:0] bumped;

  // Saturating accumulate, hand over at the boundary
  always_comb begin
    bumped = (inc && acc_q != {WIDTH{1'b1}}) ? acc_q + {{(WIDTH-1){1'b0}}, 1'b1} : acc_q;
    acc_d = bumped;
    shown_d = shown_q;
    if (boundary) begin
      shown_d = bumped;
      acc_d = '0;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      acc_q <= '0;
      shown_q <= '0;
    end else begin
      acc_q <= acc_d;
      shown_q <= shown_d;
    end
  end

endmodule : t1amc_sat_counter

// file: logic/t1amc_top.sv
`include "t1amc_params.svh"

module t1amc_top #(
  parameter int TICK_CYCLES = `T1AMC_TICK_CYCLES
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // Parallel control port
  input wire t1amc_pkg::t1amc_cpu_req_t cpu_req,
  output logic [7:0] cpu_rdata_q,
  // Status flags from the status logic
  input wire t1amc_pkg::t1amc_alarm_t alarm_flags,
  input wire t1amc_pkg::t1amc_event_t event_flags,
  // Receive framer strobes and options
  input wire t1amc_pkg::t1amc_line_evt_t line_evt,
  input wire t1amc_pkg::t1amc_cfg_t cfg,
  // Interrupt and timer outputs
  output logic irq_q,
  output logic one_second_tick_q,
  output logic interval_boundary_q
);

  // Mask registers
  logic [7:0] alarm_mask_q;
  logic [7:0] alarm_mask_d;
  logic [7:0] event_mask_q;
  logic [7:0] event_mask_d;
  logic [7:0] cpu_rdata_d;
  logic irq_d;

  // Timer state
  logic [31:0] tick_cnt_q;
  logic [31:0] tick_cnt_d;
  logic ms_tick_q;
  logic ms_tick_d;
  logic [9:0] sec_ms_q;
  logic [9:0] sec_ms_d;
  logic [5:0] fast_ms_q;
  logic [5:0] fast_ms_d;
  t1amc_pkg::t1amc_sec_phase_t phase_q;
  t1amc_pkg::t1amc_sec_phase_t phase_d;
  logic [9:0] sec_limit;
  logic sec_done;
  logic fast_done;
  logic one_second_tick_d;
  logic interval_boundary_d;

  // Zero run tracking
  logic [4:0] zero_run_q;
  logic [4:0] zero_run_d;
  logic [4:0] zero_limit;
  logic zero_hit;

  // Counter increments and held values
  logic lcv_inc;
  logic pcv_inc;
  logic oos_inc;
  logic sync_lost;
  logic [`T1AMC_LCV_WIDTH-1:0] lcv_shown;
  logic [`T1AMC_PCV_WIDTH-1:0] pcv_shown;
  logic [`T1AMC_OOS_WIDTH-1:0] oos_shown;

  assign sync_lost = alarm_flags.rx_sync_loss;

  // Mask writes and registered read data
  always_comb begin
    alarm_mask_d = alarm_mask_q;
    event_mask_d = event_mask_q;
    cpu_rdata_d = cpu_rdata_q;
    if (cpu_req.wr) begin
      if (cpu_req.addr == `T1AMC_ADDR_ALARM_MASK) begin
        alarm_mask_d = cpu_req.wdata;
      end
      if (cpu_req.addr == `T1AMC_ADDR_EVENT_MASK) begin
        event_mask_d = cpu_req.wdata;
      end
    end
    if (cpu_req.rd) begin
      unique case (cpu_req.addr)
        `T1AMC_ADDR_LCV_HIGH: cpu_rdata_d = lcv_shown[15:8];
        `T1AMC_ADDR_LCV_LOW: cpu_rdata_d = lcv_shown[7:0];
        `T1AMC_ADDR_PCV_HIGH: cpu_rdata_d = {oos_shown[11:8], pcv_shown[11:8]};
        `T1AMC_ADDR_PCV_LOW: cpu_rdata_d = pcv_shown[7:0];
        `T1AMC_ADDR_OOS_LOW: cpu_rdata_d = oos_shown[7:0];
        `T1AMC_ADDR_EVENT_MASK: cpu_rdata_d = event_mask_q;
        `T1AMC_ADDR_ALARM_MASK: cpu_rdata_d = alarm_mask_q;
        default: cpu_rdata_d = `T1AMC_RDATA_IDLE;
      endcase
    end
  end

  // Level interrupt, drops as soon as no enabled flag stays set
  always_comb begin
    irq_d = |((alarm_flags & alarm_mask_q) | (event_flags & event_mask_q));
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      alarm_mask_q <= `T1AMC_MASK_RESET;
      event_mask_q <= `T1AMC_MASK_RESET;
      cpu_rdata_q <= `T1AMC_RDATA_IDLE;
      irq_q <= 1'b0;
    end else begin
      alarm_mask_q <= alarm_mask_d;
      event_mask_q <= event_mask_d;
      cpu_rdata_q <= cpu_rdata_d;
      irq_q <= irq_d;
    end
  end

  // Millisecond enable from the clock divider
  always_comb begin
    ms_tick_d = 1'b0;
    tick_cnt_d = tick_cnt_q + 32'h0000_0001;
    if (tick_cnt_q == 32'(TICK_CYCLES - 1)) begin
      tick_cnt_d = '0;
      ms_tick_d = 1'b1;
    end
  end

  // Third second runs long so three seconds total exactly 3000 ms
  always_comb begin
    unique case (phase_q)
      t1amc_pkg::T1AMC_SEC_A: sec_limit = 10'(`T1AMC_SEC_SHORT_MS);
      t1amc_pkg::T1AMC_SEC_B: sec_limit = 10'(`T1AMC_SEC_SHORT_MS);
      t1amc_pkg::T1AMC_SEC_C: sec_limit = 10'(`T1AMC_SEC_LONG_MS);
      default: sec_limit = 10'(`T1AMC_SEC_SHORT_MS);
    endcase
  end

  assign sec_done = ms_tick_q && (sec_ms_q == sec_limit - 10'h001);
  assign fast_done = ms_tick_q && (fast_ms_q == 6'(`T1AMC_FAST_MS - 1));

  // Second and 42 ms interval counters
  always_comb begin
    sec_ms_d = sec_ms_q;
    fast_ms_d = fast_ms_q;
    phase_d = phase_q;
    if (ms_tick_q) begin
      sec_ms_d = sec_ms_q + 10'h001;
      fast_ms_d = fast_ms_q + 6'h01;
    end
    if (sec_done) begin
      sec_ms_d = '0;
      unique case (phase_q)
        t1amc_pkg::T1AMC_SEC_A: phase_d = t1amc_pkg::T1AMC_SEC_B;
        t1amc_pkg::T1AMC_SEC_B: phase_d = t1amc_pkg::T1AMC_SEC_C;
        t1amc_pkg::T1AMC_SEC_C: phase_d = t1amc_pkg::T1AMC_SEC_A;
        default: phase_d = t1amc_pkg::T1AMC_SEC_A;
      endcase
    end
    if (fast_done) begin
      fast_ms_d = '0;
    end
    one_second_tick_d = sec_done;
    interval_boundary_d = cfg.count_interval_select ? fast_done : sec_done;
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      tick_cnt_q <= '0;
      ms_tick_q <= 1'b0;
      sec_ms_q <= '0;
      fast_ms_q <= '0;
      phase_q <= t1amc_pkg::T1AMC_SEC_A;
      one_second_tick_q <= 1'b0;
      interval_boundary_q <= 1'b0;
    end else begin
      tick_cnt_q <= tick_cnt_d;
      ms_tick_q <= ms_tick_d;
      sec_ms_q <= sec_ms_d;
      fast_ms_q <= fast_ms_d;
      phase_q <= phase_d;
      one_second_tick_q <= one_second_tick_d;
      interval_boundary_q <= interval_boundary_d;
    end
  end

  // Zero run detector; each full run counts once, then restarts
  assign zero_limit = cfg.rx_zero_substitution_enable ? 5'(`T1AMC_ZERO_RUN_SUBST)
                                                      : 5'(`T1AMC_ZERO_RUN_PLAIN);
  assign zero_hit = line_evt.bit_valid && line_evt.bit_zero && (zero_run_q == zero_limit - 5'h01);

  always_comb begin
    zero_run_d = zero_run_q;
    if (line_evt.bit_valid) begin
      if (!line_evt.bit_zero || zero_hit) begin
        zero_run_d = '0;
      end else begin
        zero_run_d = zero_run_q + 5'h01;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      zero_run_q <= '0;
    end else begin
      zero_run_q <= zero_run_d;
    end
  end

  // Counter qualifiers; a violation and a zero run together count once
  always_comb begin
    lcv_inc = (line_evt.bipolar_violation
               && !(cfg.rx_zero_substitution_enable && line_evt.in_subst_codeword))
              || (cfg.excess_zero_count_enable && zero_hit);
    if (cfg.framing_mode_select) begin
      pcv_inc = line_evt.crc6_error;
    end else begin
      pcv_inc = line_evt.ft_error || (cfg.fs_error_count_enable && line_evt.fs_error);
    end
    pcv_inc = pcv_inc && !sync_lost;
    if (cfg.out_of_sync_count_select) begin
      oos_inc = line_evt.multiframe && sync_lost;
    end else begin
      oos_inc = !sync_lost && (cfg.framing_mode_select ? line_evt.fps_error : line_evt.ft_error);
    end
  end

  // Three counters share one boundary strobe
  t1amc_sat_counter #(
    .WIDTH(`T1AMC_LCV_WIDTH)
  ) u_lcv (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .inc(lcv_inc),
    .boundary(interval_boundary_d),
    .shown_q(lcv_shown)
  );

  t1amc_sat_counter #(
    .WIDTH(`T1AMC_PCV_WIDTH)
  ) u_pcv (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .inc(pcv_inc),
    .boundary(interval_boundary_d),
    .shown_q(pcv_shown)
  );

  t1amc_sat_counter #(
    .WIDTH(`T1AMC_OOS_WIDTH)
  ) u_oos (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .inc(oos_inc),
    .boundary(interval_boundary_d),
    .shown_q(oos_shown)
  );

endmodule : t1amc_top

// file: verification/t1amc_host.sv
module t1amc_host (
  // Clock
  input wire logic sys_clk,
  // Control port
  output t1amc_pkg::t1amc_cpu_req_t cpu_req,
  input wire logic [7:0] cpu_rdata_q
);
  timeunit 1ns;
  timeprecision 100ps;
  initial cpu_req = '0;
  // One access; strobe held for exactly the taking edge
  task automatic access(input logic w, input logic [7:0] a, input logic [7:0] wd, output logic [7:0] d);
    @(posedge sys_clk);
    #1;
    cpu_req = {w, !w, a, wd};
    @(posedge sys_clk);
    #1;
    // Idle lines show the inverse, never a stale copy
    cpu_req = {2'b00, ~a, ~wd};
    d = cpu_rdata_q;
  endtask : access
endmodule : t1amc_host

// file: verification/t1amc_chk.sv
module t1amc_chk #(
  parameter int TICK_CYCLES = 4
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // Control port
  input wire t1amc_pkg::t1amc_cpu_req_t cpu_req,
  input wire logic [7:0] cpu_rdata_q,
  // Status and options
  input wire t1amc_pkg::t1amc_alarm_t alarm_flags,
  input wire t1amc_pkg::t1amc_event_t event_flags,
  input wire t1amc_pkg::t1amc_line_evt_t line_evt,
  input wire t1amc_pkg::t1amc_cfg_t cfg,
  // Outputs
  input wire logic irq_q,
  input wire logic one_second_tick_q,
  input wire logic interval_boundary_q
);
  logic [7:0] am_q, am_d, em_q, em_d;
  int gap_q, gap_d;
  logic seen_q, seen_d, hit;
  int sgap_q, sgap_d;
  logic sseen_q, sseen_d;
  // Shadow masks, enabled hit, cycles since boundary
  always_comb begin
    am_d = am_q;
    em_d = em_q;
    if (cpu_req.wr && cpu_req.addr == 8'h7f) am_d = cpu_req.wdata;
    if (cpu_req.wr && cpu_req.addr == 8'h6f) em_d = cpu_req.wdata;
    hit = |({alarm_flags, event_flags} & {am_q, em_q});
    gap_d = interval_boundary_q ? 0 : gap_q + 1;
    seen_d = seen_q | interval_boundary_q;
    sgap_d = one_second_tick_q ? 0 : sgap_q + 1;
    sseen_d = sseen_q | one_second_tick_q;
  end
  // First interval after reset has no known start
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      am_q <= 8'h00;
      em_q <= 8'h00;
      gap_q <= 0;
      seen_q <= 1'b0;
      sgap_q <= 0;
      sseen_q <= 1'b0;
    end else begin
      am_q <= am_d;
      em_q <= em_d;
      gap_q <= gap_d;
      seen_q <= seen_d;
      sgap_q <= sgap_d;
      sseen_q <= sseen_d;
    end
  end
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  alarm_rdback_a: assert property (cpu_req.rd && cpu_req.addr == 8'h7f |=> cpu_rdata_q == $past(am_q))
    else $error("alarm mask readback wrong");
  event_rdback_a: assert property (cpu_req.rd && cpu_req.addr == 8'h6f |=> cpu_rdata_q == $past(em_q))
    else $error("event mask readback wrong");
  irq_follow_a: assert property (irq_q == $past(hit))
    else $error("irq does not follow masked flags");
  interval_len_a: assert property (interval_boundary_q && seen_q && cfg.count_interval_select |-> gap_q == 42 * TICK_CYCLES - 1)
    else $error("short interval length wrong");
  bound_gap_a: assert property (interval_boundary_q |=> !interval_boundary_q [*8])
    else $error("boundaries too close");
  rdata_hold_a: assert property (!cpu_req.rd |=> $stable(cpu_rdata_q))
    else $error("read data changed without read");
  unmapped_zero_a: assert property (cpu_req.rd && cpu_req.addr == 8'h40 |=> cpu_rdata_q == 8'h00)
    else $error("unmapped read not zero");
  sec_pulse_a: assert property (one_second_tick_q |=> !one_second_tick_q)
    else $error("second tick longer than one cycle");
  sec_len_a: assert property (one_second_tick_q && sseen_q |-> sgap_q == 999 * TICK_CYCLES - 1 || sgap_q == 1002 * TICK_CYCLES - 1)
    else $error("second length wrong");
  sec_mode_a: assert property (!$past(cfg.count_interval_select) |-> interval_boundary_q == one_second_tick_q)
    else $error("second mode boundary not on second tick");
  sec_c: cover property (one_second_tick_q);
  bd_c: cover property (interval_boundary_q);
  irq_c: cover property ($rose(irq_q));
  pcv_c: cover property (cpu_req.rd && cpu_req.addr == 8'h25);
endmodule : t1amc_chk

bind t1amc_top t1amc_chk #(.TICK_CYCLES(TICK_CYCLES)) t1amc_chk_i (.sys_clk(sys_clk), .rst_n(rst_n),
  .cpu_req(cpu_req), .cpu_rdata_q(cpu_rdata_q), .alarm_flags(alarm_flags), .event_flags(event_flags),
  .line_evt(line_evt), .cfg(cfg), .irq_q(irq_q), .one_second_tick_q(one_second_tick_q),
  .interval_boundary_q(interval_boundary_q));

// file: verification/tb_t1amc_top.sv
module tb_t1amc_top;
  timeunit 1ns;
  timeprecision 100ps;
  logic sys_clk, rst_n, irq_q, one_second_tick_q, interval_boundary_q;
  t1amc_pkg::t1amc_cpu_req_t cpu_req;
  logic [7:0] cpu_rdata_q, rdv;
  t1amc_pkg::t1amc_alarm_t alarm_flags;
  t1amc_pkg::t1amc_event_t event_flags;
  t1amc_pkg::t1amc_line_evt_t line_evt;
  t1amc_pkg::t1amc_cfg_t cfg;
  int err_count, checked;
  int cyc, tick_cyc, sec_len;
  // Five-cycle ms tick: 42 ms is 210 cycles, a second about 5000
  localparam int TICK = 5;
  t1amc_top #(.TICK_CYCLES(TICK)) t1amc_top_i (.sys_clk(sys_clk), .rst_n(rst_n), .cpu_req(cpu_req),
    .cpu_rdata_q(cpu_rdata_q), .alarm_flags(alarm_flags), .event_flags(event_flags), .line_evt(line_evt),
    .cfg(cfg), .irq_q(irq_q), .one_second_tick_q(one_second_tick_q), .interval_boundary_q(interval_boundary_q));
  t1amc_host t1amc_host_i (.sys_clk(sys_clk), .cpu_req(cpu_req), .cpu_rdata_q(cpu_rdata_q));
  initial begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end
  // Cycles between second ticks, sampled mid-cycle where the pulse is settled
  initial begin
    cyc = 0;
    tick_cyc = 0;
    sec_len = 0;
    forever begin
      @(negedge sys_clk);
      cyc++;
      if (one_second_tick_q === 1'b1) begin
        sec_len = cyc - tick_cyc;
        tick_cyc = cyc;
      end
    end
  end
  task automatic results;
    if (err_count == 0 && checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : results
  task automatic cmp_rd(input logic [7:0] a, input logic [7:0] exp);
    t1amc_host_i.access(1'b0, a, 8'h00, rdv);
    checked++;
    if (rdv !== exp) begin
      err_count++;
      $display("Error reg %h expected %h seen %h", a, exp, rdv);
    end
  endtask : cmp_rd
  task automatic cmp_irq(input logic exp);
    checked++;
    if (irq_q !== exp) begin
      err_count++;
      $display("Error irq_q expected %b seen %b", exp, irq_q);
    end
  endtask : cmp_irq
  task automatic cmp_sec(input int exp);
    checked++;
    if (sec_len != exp) begin
      err_count++;
      $display("Error second length expected %0d seen %0d", exp, sec_len);
    end
  endtask : cmp_sec
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    t1amc_host_i.access(1'b1, a, d, rdv);
  endtask : wr
  // Strobe held n cycles, one idle cycle ahead
  task automatic pulse(input logic [8:0] e, input int n);
    @(posedge sys_clk);
    #1;
    line_evt = e;
    repeat (n) @(posedge sys_clk);
    #1;
    line_evt = '0;
  endtask : pulse
  // Bounded wait; a missing boundary counts as a mismatch
  task automatic wait_bd;
    int n;
    n = 0;
    do begin
      @(posedge sys_clk);
      #1;
      n++;
    end while (interval_boundary_q !== 1'b1 && n < 5100);
    if (interval_boundary_q !== 1'b1) begin
      err_count++;
      $display("Error interval_boundary_q expected 1 seen 0");
    end
  endtask : wait_bd
  initial begin
    repeat (40000) @(posedge sys_clk);
    err_count++;
    results();
  end
  initial begin
    logic [15:0] m;
    rst_n = 1'b0;
    alarm_flags = '0;
    event_flags = '0;
    line_evt = '0;
    cfg = 6'b110010;
    err_count = 0;
    checked = 0;
    repeat (8) @(posedge sys_clk);
    #1;
    rst_n = 1'b1;
    cmp_rd(8'h7f, 8'h00);
    cmp_rd(8'h6f, 8'h00);
    wr(8'h7f, 8'ha5);
    wr(8'h6f, 8'h5a);
    wr(8'h24, 8'hff);
    cmp_rd(8'h7f, 8'ha5);
    cmp_rd(8'h6f, 8'h5a);
    cmp_rd(8'h24, 8'h00);
    cmp_rd(8'h40, 8'h00);
    // Each source alone: others set but masked, then all set
    for (int i = 0; i < 16; i++) begin
      m = 16'h0001 << i;
      wr(8'h7f, m[15:8]);
      wr(8'h6f, m[7:0]);
      {alarm_flags, event_flags} = ~m;
      repeat (3) @(posedge sys_clk);
      #1;
      cmp_irq(1'b0);
      {alarm_flags, event_flags} = 16'hffff;
      repeat (3) @(posedge sys_clk);
      #1;
      cmp_irq(1'b1);
    end
    {alarm_flags, event_flags} = 16'h0000;
    wait_bd();
    pulse(9'h180, 16);
    pulse(9'h008, 2);
    pulse(9'h004, 1);
    alarm_flags.rx_sync_loss = 1'b1;
    pulse(9'h040, 3);
    pulse(9'h060, 1);
    pulse(9'h008, 1);
    alarm_flags.rx_sync_loss = 1'b0;
    wait_bd();
    cmp_rd(8'h23, 8'h00);
    cmp_rd(8'h24, 8'h05);
    cmp_rd(8'h25, 8'h00);
    cmp_rd(8'h26, 8'h03);
    cmp_rd(8'h27, 8'h02);
    cfg.rx_zero_substitution_enable = 1'b1;
    cfg.framing_mode_select = 1'b1;
    pulse(9'h180, 8);
    pulse(9'h060, 1);
    pulse(9'h040, 1);
    pulse(9'h010, 2);
    pulse(9'h004, 1);
    pulse(9'h008, 1);
    pulse(9'h002, 2);
    alarm_flags.rx_sync_loss = 1'b1;
    pulse(9'h010, 1);
    alarm_flags.rx_sync_loss = 1'b0;
    wait_bd();
    cmp_rd(8'h24, 8'h02);
    cmp_rd(8'h26, 8'h02);
    cmp_rd(8'h25, 8'h00);
    cmp_rd(8'h27, 8'h02);
    // Violations close with the partial interval at the first second tick
    pulse(9'h040, 3);
    cfg.count_interval_select = 1'b0;
    wait_bd();
    pulse(9'h010, 4100);
    cmp_rd(8'h24, 8'h03);
    cfg.out_of_sync_count_select = 1'b1;
    alarm_flags.rx_sync_loss = 1'b1;
    pulse(9'h001, 5);
    alarm_flags.rx_sync_loss = 1'b0;
    pulse(9'h001, 1);
    cfg.excess_zero_count_enable = 1'b0;
    pulse(9'h180, 8);
    wait_bd();
    cmp_rd(8'h25, 8'h0f);
    cmp_rd(8'h26, 8'hff);
    cmp_rd(8'h24, 8'h00);
    cmp_rd(8'h27, 8'h05);
    cmp_sec(999 * TICK);
    wait_bd();
    cmp_rd(8'h26, 8'h00);
    cmp_sec(1002 * TICK);
    results();
  end
endmodule : tb_t1amc_top
